// >>> test/uartrx_core_asserts.sv
// Port-level assertions for the UART receiver core
`timescale 1ns/1ps
`default_nettype none
`include "uartrx_consts.svh"
module uartrx_core_asserts (
  // Clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  // Register port
  input  wire uartrx_pkg::uartrx_bus_s i_bus,
  input  wire logic [7:0]              o_rdata,
  // Line, clock state and transmitter levels
  input  wire logic                    i_rx,
  input  wire logic                    i_clk_stopped,
  input  wire logic                    i_tx_empty,
  input  wire logic                    i_tx_idle,
  // Interrupt request
  input  wire logic                    o_irq_n
);
  import uartrx_pkg::*;
  logic [7:0] ctrl2_q;
  logic [3:0] quiet_q;
  logic [3:0] txw_q;
  logic       tx_src;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Shadow of the enable register, since the checker cannot see inside
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) ctrl2_q <= `UARTRX_CTRL2_RST;
    else if (i_ce && i_bus.wr && i_bus.addr == `UARTRX_OFF_CTRL2) ctrl2_q <= i_bus.wdata;
  end
  // Cycles with every interrupt enable off; pending pulses drain first
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) quiet_q <= 4'h0;
    else if (ctrl2_q[5] | ctrl2_q[1] | ctrl2_q[0]) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  // Cycles an enabled transmit source waits without a pulse
  assign tx_src = (ctrl2_q[`UARTRX_C2_TEIE] & i_tx_empty) | (ctrl2_q[`UARTRX_C2_TIIE] & i_tx_idle);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) txw_q <= 4'h0;
    else if (!tx_src || !o_irq_n) txw_q <= 4'h0;
    else if (txw_q != 4'hf) txw_q <= txw_q + 4'h1;
  end
  property p_irq_pulse; !o_irq_n && i_ce |=> o_irq_n; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq low two cycles");
  property p_quiet; quiet_q >= 4'h4 |-> o_irq_n; endproperty
  a_quiet: assert property (p_quiet) else $error("irq while all masked");
  property p_tx_src; txw_q <= 4'h4; endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx source gave no pulse");
  property p_wake;
    i_clk_stopped && ctrl2_q[`UARTRX_C2_RIE] && ctrl2_q[`UARTRX_C2_WAKE] && $fell(i_rx)
      |-> ##[1:4] !o_irq_n;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request");
  property p_unmapped; i_bus.rd && i_bus.addr > `UARTRX_OFF_BAUD |=> o_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_idle; $past(i_ce) && !$past(i_bus.rd) |-> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_ctrl2_rb; i_bus.rd && i_bus.addr == `UARTRX_OFF_CTRL2 |=> o_rdata == ctrl2_q; endproperty
  a_ctrl2_rb: assert property (p_ctrl2_rb) else $error("enable readback wrong");
  property p_tx_bits;
    i_bus.rd && i_bus.addr == `UARTRX_OFF_STATUS && $stable(i_tx_empty) && $stable(i_tx_idle)
      |=> o_rdata[7:6] == {$past(i_tx_empty), $past(i_tx_idle)};
  endproperty
  a_tx_bits: assert property (p_tx_bits) else $error("tx status bits wrong");
endmodule : uartrx_core_asserts
bind uartrx_core uartrx_core_asserts uartrx_core_asserts_i (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata), .i_rx(i_rx),
  .i_clk_stopped(i_clk_stopped), .i_tx_empty(i_tx_empty), .i_tx_idle(i_tx_idle),
  .o_irq_n(o_irq_n));
`default_nettype wire

// >>> test/uartrx_core_tb.sv
// Self-checking bench for the UART receiver core
`timescale 1ns/1ps
`default_nettype none
`include "uartrx_consts.svh"
module uartrx_core_tb;
  import uartrx_pkg::*;
  localparam logic [3:0] ST = `UARTRX_OFF_STATUS;
  localparam logic [3:0] DT = `UARTRX_OFF_DATA;
  localparam logic [3:0] C1 = `UARTRX_OFF_CTRL1;
  localparam logic [3:0] C2 = `UARTRX_OFF_CTRL2;
  logic        i_clk_sys, i_rst, i_ce, i_rx, i_clk_stopped, i_tx_empty, i_tx_idle, o_irq_n;
  uartrx_bus_s bus;
  logic [7:0]  o_rdata, s, d;
  logic [8:0]  w, b0, b1;
  int          n_mismatch, tests_run, n_irq, i0, cyc, seed, k;
  uartrx_core #(.DEPTH(2)) uartrx_core_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
    .i_bus(bus), .o_rdata(o_rdata), .i_rx(i_rx), .i_clk_stopped(i_clk_stopped),
    .i_tx_empty(i_tx_empty), .i_tx_idle(i_tx_idle), .o_irq_n(o_irq_n));
  uartrx_tx_model #(.BIT_CYC(16)) uartrx_tx_model_i (.i_clk_sys(i_clk_sys), .o_rx(i_rx));
  initial i_clk_sys = 1'b0;
  always #10 i_clk_sys = ~i_clk_sys;
  // Pulse counter and hang guard; the ceiling is several times the planned run
  always @(posedge i_clk_sys) begin
    cyc++;
    if (!i_rst && o_irq_n === 1'b0) n_irq++;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_clk_sys);
    bus <= '0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk_sys);
    bus <= '0;
    @(negedge i_clk_sys);
    v = o_rdata;
  endtask : rd
  // Parity bit in bit 7: even keeps the xor of all eight bits at zero
  function automatic logic [8:0] par_word(input logic [6:0] v, input logic odd, input logic bad);
    return {1'b0, (^v) ^ odd ^ bad, v};
  endfunction : par_word
  initial begin
    seed = 19;
    bus = '0;
    i_ce = 1'b1;
    i_clk_stopped = 1'b0;
    i_tx_empty = 1'b0;
    i_tx_idle = 1'b0;
    i_rst = 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(C2, s); chk(s, `UARTRX_CTRL2_RST);
    rd(4'hb, s); chk(s, 8'h00);
    wr(`UARTRX_OFF_BAUD, 8'h00);
    wr(C2, 8'ha0);
    // Random words, one pulse each, flag cleared by status then data
    for (k = 0; k < 4; k++) begin
      w = {1'b0, 8'($random(seed))};
      i0 = n_irq;
      uartrx_tx_model_i.send(w, 8, 1'b1, 1'b0, 4);
      chk(n_irq - i0, 1);
      rd(ST, s); chk(s & 8'h3f, 8'h30);
      rd(DT, d); chk(d, w[7:0]);
      rd(ST, s); chk(s & 8'h20, 8'h00);
    end
    // A data read not preceded by a status read must not pop
    rd(DT, d); // Drops the clear that the last status read left pending
    uartrx_tx_model_i.send(9'h0a5, 8, 1'b1, 1'b0, 4);
    rd(DT, d);
    rd(ST, s); chk(s & 8'h20, 8'h20);
    rd(DT, d); chk(d, 8'ha5);
    // Three words unread: overrun, first two kept
    b0 = {1'b0, 8'($random(seed))};
    b1 = {1'b0, 8'($random(seed))};
    uartrx_tx_model_i.send(b0, 8, 1'b1, 1'b0, 4);
    uartrx_tx_model_i.send(b1, 8, 1'b1, 1'b0, 4);
    i0 = n_irq;
    uartrx_tx_model_i.send(9'h1ff ^ b0, 8, 1'b1, 1'b0, 4);
    chk(n_irq != i0, 1);
    rd(ST, s); chk(s & 8'h28, 8'h28);
    rd(DT, d); chk(d, b0[7:0]);
    rd(ST, s); chk(s & 8'h28, 8'h20);
    rd(DT, d); chk(d, b1[7:0]);
    rd(ST, s); chk(s & 8'h20, 8'h00);
    // Even and odd parity, good and bad
    for (k = 0; k < 4; k++) begin
      wr(C1, {2'b00, 1'b1, k[1], 4'h0});
      w = par_word(7'($random(seed)), k[1], k[0]);
      uartrx_tx_model_i.send(w, 8, 1'b1, 1'b0, 4);
      rd(ST, s); chk(s & 8'h01, {7'h00, k[0]});
      rd(DT, d); chk(d, w[7:0]);
    end
    // Nine-bit words under address detect
    wr(C1, 8'h40);
    wr(C2, 8'ha8);
    for (k = 0; k < 2; k++) begin
      w = {k[0], 8'($random(seed)) | 8'h80};
      i0 = n_irq;
      uartrx_tx_model_i.send(w, 9, 1'b1, 1'b0, 4);
      chk(n_irq - i0, k);
      rd(ST, s);
      rd(DT, d); chk(d, w[7:0]);
      rd(C1, s); chk(s[1], w[8]);
    end
    // Noisy sample still delivers the word with its noise flag
    wr(C1, 8'h00);
    wr(C2, 8'ha0);
    uartrx_tx_model_i.send(9'h03c, 8, 1'b1, 1'b1, 4);
    rd(ST, s); chk(s & 8'h22, 8'h22);
    rd(DT, d); chk(d, 8'h3c);
    rd(ST, s); chk(s & 8'h02, 8'h00);
    // Clock enable low freezes state, so this write must not land
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    wr(C1, 8'h30);
    i_ce <= 1'b1;
    rd(C1, s); chk(s, 8'h00);
    // Long break: one zero word, framing error, no second start
    fork
      uartrx_tx_model_i.send(9'h000, 8, 1'b0, 1'b0, 300);
      begin
        repeat (60) @(posedge i_clk_sys);
        rd(ST, s); chk(s & 8'h10, 8'h00);
      end
    join
    repeat (40) @(posedge i_clk_sys);
    rd(ST, s); chk(s & 8'h34, 8'h34);
    rd(DT, d); chk(d, 8'h00);
    rd(ST, s); chk(s & 8'h30, 8'h10);
    // Wake request with the clock reported stopped
    wr(C2, 8'ha4);
    i_clk_stopped <= 1'b1;
    i0 = n_irq;
    uartrx_tx_model_i.send(9'h0f0, 8, 1'b1, 1'b0, 4);
    i_clk_stopped <= 1'b0;
    // One wake pulse at the start edge plus one for the stored word
    chk(n_irq - i0, 2);
    rd(ST, s);
    rd(DT, d); chk(d, 8'hf0);
    // Transmit sources with their own enables, random levels
    wr(C2, 8'h03);
    for (k = 0; k < 24; k++) begin
      @(posedge i_clk_sys);
      i_tx_empty <= 1'($random(seed));
      i_tx_idle <= 1'($random(seed));
    end
    rd(ST, s); chk(s[7:6], {i_tx_empty, i_tx_idle});
    i0 = n_irq;
    wr(C2, 8'h00);
    repeat (6) @(posedge i_clk_sys);
    chk(n_irq - i0 < 3, 1);
    give_verdict();
  end
endmodule : uartrx_core_tb
`default_nettype wire

// >>> test/uartrx_tx_model.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uartrx_tx_model #(
  parameter int BIT_CYC = 16
) (
  // Clock and line
  input  wire logic i_clk_sys,
  output logic      o_rx
);
  initial o_rx = 1'b1;
  // One frame; the stop level is then held for gap cycles before idling high
  task automatic send(input logic [8:0] w, input int nb, input logic stp, input logic glitch,
                      input int gap);
    int k;
    int c;
    logic [10:0] f;
    f = 11'h000;
    for (k = 0; k < nb; k++) f[k + 1] = w[k];
    f[nb + 1] = stp;
    for (k = 0; k < nb + 2; k++) begin
      for (c = 0; c < BIT_CYC; c++) begin
        @(posedge i_clk_sys);
        o_rx <= (glitch && k == 1 && c == 9) ? ~f[k] : f[k];
      end
    end
    repeat (gap) @(posedge i_clk_sys);
    o_rx <= 1'b1;
  endtask : send
endmodule : uartrx_tx_model
`default_nettype wire

// >>> verilog/uartrx_consts.svh
// Constants for the UART receiver: register offsets, field positions, timing
`ifndef UARTRX_CONSTS_SVH
`define UARTRX_CONSTS_SVH
`define UARTRX_ADDR_W        4
`define UARTRX_OFF_STATUS    4'h0
`define UARTRX_OFF_DATA      4'h1
`define UARTRX_OFF_CTRL1     4'h2
`define UARTRX_OFF_CTRL2     4'h3
`define UARTRX_OFF_BAUD      4'h4
`define UARTRX_ST_PARITY_ERR_FLAG       0
`define UARTRX_ST_NF         1
`define UARTRX_ST_FRAME_ERR_FLAG       2
`define UARTRX_ST_OVERRUN_FLAG       3
`define UARTRX_ST_RX_IDLE_FLAG      4
`define UARTRX_ST_RXAV       5
`define UARTRX_ST_TIDLE      6
`define UARTRX_ST_TXEMP      7
`define UARTRX_C1_PARODD     4
`define UARTRX_C1_PAREN      5
`define UARTRX_C1_NINE       6
`define UARTRX_C1_RXB8       1
`define UARTRX_C2_RX_ENABLE_BIT       7
`define UARTRX_C2_ADDR       3
`define UARTRX_C2_WAKE       2
`define UARTRX_C2_RIE        5
`define UARTRX_C2_TIIE       1
`define UARTRX_C2_TEIE       0
`define UARTRX_CTRL1_RST     8'h00
`define UARTRX_CTRL2_RST     8'h00
`define UARTRX_BAUD_RST      8'h00
`define UARTRX_OVS           5'h10
`define UARTRX_SAMP_A        4'h7
`define UARTRX_SAMP_B        4'h8
`define UARTRX_SAMP_C        4'h9
`endif

// >>> verilog/uartrx_core.sv
// UART receive path with two-entry buffer, error flags and interrupt logic
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "uartrx_consts.svh"
module uartrx_core #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // Register port
  input  wire uartrx_pkg::uartrx_bus_s i_bus,
  output logic [7:0]                o_rdata,
  // Serial line and clock state
  input  wire logic                 i_rx,
  input  wire logic                 i_clk_stopped,
  // Transmitter condition inputs
  input  wire logic                 i_tx_empty,
  input  wire logic                 i_tx_idle,
  // Interrupt request, active low pulse
  output logic                      o_irq_n
);
  import uartrx_pkg::*;

  uartrx_state_e state_q;
  uartrx_word_s  fifo_q [DEPTH];
  logic [1:0]    count_q;
  logic          rd_ptr_q;
  logic          wr_ptr_q;
  logic [7:0]    ctrl1_q;
  logic [7:0]    ctrl2_q;
  logic [7:0]    baud_q;
  logic [7:0]    div_q;
  logic [3:0]    tick_q;
  logic [3:0]    bit_q;
  logic [8:0]    shift_q;
  logic          noise_acc_q;
  logic          par_acc_q;
  logic          wait_high_q;
  logic          rx_idle_flag_q;
  logic          overrun_flag_q;
  logic          noise_q;
  logic          armed_q;
  logic          rx_prev_q;
  logic          irq_n_q;
  logic [7:0]    rdata_q;

  logic          os_tick;
  logic          level;
  logic          noisy;
  logic          nine;
  logic [3:0]    data_bits;
  logic          par_en;
  logic          push;
  logic          pop;
  logic          full;
  logic          stop_done;
  logic          rd_stat;
  logic          rd_data;
  logic          st_frame_err_flag;
  logic          st_parity_err_flag;
  logic [7:0]    status;
  logic [8:0]    word_in;
  logic          par_bad;
  logic          avail;
  logic          irq_evt;
  uartrx_word_s  head;

  assign nine      = ctrl1_q[`UARTRX_C1_NINE];
  assign par_en    = ctrl1_q[`UARTRX_C1_PAREN];
  assign data_bits = nine ? 4'h9 : 4'h8;
  assign rd_stat   = i_bus.rd && (i_bus.addr == `UARTRX_OFF_STATUS);
  assign rd_data   = i_bus.rd && (i_bus.addr == `UARTRX_OFF_DATA);
  assign full      = (count_q == 2'(DEPTH));
  assign head      = fifo_q[rd_ptr_q];
  assign avail     = (count_q != 2'h0);

  // Oversample tick: divisor register sets rate at sixteen ticks per bit
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 8'h00;
    end else if (i_ce) begin
      if (div_q >= baud_q) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end
  assign os_tick = (div_q >= baud_q);

  uartrx_vote u_vote (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_clr     (os_tick && (tick_q == 4'hf)),
    .i_take    (os_tick && (tick_q == `UARTRX_SAMP_A || tick_q == `UARTRX_SAMP_B ||
                            tick_q == `UARTRX_SAMP_C)),
    .i_pin     (i_rx),
    .o_level   (level),
    .o_noisy   (noisy)
  );

  // Stop bit is judged one tick after the last sample
  assign stop_done = (state_q == UARTRX_STOP) && os_tick && (tick_q == 4'ha);
  assign par_bad   = par_acc_q ^ ctrl1_q[`UARTRX_C1_PARODD];
  // Break word stores zeros; a low stop bit with all-zero data is a break
  assign word_in   = (~level && (shift_q == 9'h000)) ? 9'h000 : shift_q;
  // Push only while a slot is free; a full buffer turns the word into overrun
  assign push      = stop_done && !full;
  // A data read after a status read pops one entry
  assign pop       = rd_data && armed_q && avail;

  // Receive sequencer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q     <= UARTRX_IDLE;
      tick_q      <= 4'h0;
      bit_q       <= 4'h0;
      shift_q     <= 9'h000;
      noise_acc_q <= 1'b0;
      par_acc_q   <= 1'b0;
      wait_high_q <= 1'b0;
    end else if (i_ce) begin
      if (!ctrl2_q[`UARTRX_C2_RX_ENABLE_BIT]) begin
        state_q     <= UARTRX_IDLE;
        wait_high_q <= 1'b0;
      end else if (os_tick) begin
        tick_q <= tick_q + 4'h1;
        case (state_q)
          UARTRX_IDLE: begin
            tick_q <= 4'h0;
            // Hold off after a break until the line returns high
            if (i_rx) begin
              wait_high_q <= 1'b0;
            end else if (!wait_high_q) begin
              state_q     <= UARTRX_START;
              noise_acc_q <= 1'b0;
              par_acc_q   <= 1'b0;
              shift_q     <= 9'h000;
            end
          end
          UARTRX_START: begin
            if (tick_q == 4'ha) begin
              // False start if centre majority is high
              state_q <= level ? UARTRX_IDLE : UARTRX_START;
              noise_acc_q <= noise_acc_q | noisy;
            end
            if (tick_q == 4'hf && !level) begin
              state_q <= UARTRX_DATA;
              bit_q   <= 4'h0;
            end
          end
          UARTRX_DATA: begin
            if (tick_q == 4'ha) begin
              // Shift in LSB first, right-aligned to the word length
              shift_q <= nine ? {level, shift_q[8:1]} : {1'b0, level, shift_q[7:1]};
              noise_acc_q <= noise_acc_q | noisy;
              par_acc_q   <= par_acc_q ^ level;
            end
            if (tick_q == 4'hf) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == data_bits - 4'h1) begin
                state_q <= UARTRX_STOP;
              end
            end
          end
          UARTRX_STOP: begin
            // Only the first stop bit is checked
            if (tick_q == 4'ha) begin
              state_q     <= UARTRX_IDLE;
              wait_high_q <= ~level;
            end
          end
          default: state_q <= UARTRX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer entries, written at the write pointer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        fifo_q[i] <= '0;
      end
    end else if (i_ce && push) begin
      // Error flags travel with their word
      fifo_q[wr_ptr_q] <= '{data:  word_in,
                            frame_err_flag:  ~level,
                            parity_err_flag:  par_en & par_bad,
                            noise: noise_acc_q | noisy};
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_q  <= 2'h0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Idle flag drops at start detection and rises at the stop sample
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_idle_flag_q <= 1'b1;
    end else if (i_ce) begin
      if (state_q == UARTRX_START) begin
        rx_idle_flag_q <= 1'b0;
      end else if (stop_done) begin
        rx_idle_flag_q <= 1'b1;
      end
    end
  end

  // Status access arms the clear; the next data read completes it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (i_ce) begin
      if (rd_stat) begin
        armed_q <= 1'b1;
      end else if (rd_data) begin
        armed_q <= 1'b0;
      end
    end
  end

  // Overrun: buffered words kept, arriving word dropped; set beats clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      overrun_flag_q <= 1'b0;
    end else if (i_ce) begin
      if (stop_done && full) begin
        overrun_flag_q <= 1'b1;
      end else if (rd_data && armed_q) begin
        overrun_flag_q <= 1'b0;
      end
    end
  end

  // Noise flag follows the head word as data-available rises
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      noise_q <= 1'b0;
    end else if (i_ce) begin
      if (push && !avail) begin
        noise_q <= noise_acc_q | noisy;
      end else if (pop) begin
        noise_q <= (count_q == 2'h2) ? fifo_q[~rd_ptr_q].noise : (push & (noise_acc_q | noisy));
      end
    end
  end

  // Status is assembled from hardware state only
  assign st_frame_err_flag = avail & head.frame_err_flag;
  assign st_parity_err_flag = avail & head.parity_err_flag;
  always_comb begin
    status = 8'h00;
    status[`UARTRX_ST_PARITY_ERR_FLAG]  = st_parity_err_flag;
    status[`UARTRX_ST_NF]    = noise_q;
    status[`UARTRX_ST_FRAME_ERR_FLAG]  = st_frame_err_flag;
    status[`UARTRX_ST_OVERRUN_FLAG]  = overrun_flag_q;
    status[`UARTRX_ST_RX_IDLE_FLAG] = rx_idle_flag_q;
    status[`UARTRX_ST_RXAV]  = avail;
    status[`UARTRX_ST_TIDLE] = i_tx_idle;
    status[`UARTRX_ST_TXEMP] = i_tx_empty;
  end

  // Writable control registers; status is read-only so writes there are dropped
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl1_q <= `UARTRX_CTRL1_RST;
      ctrl2_q <= `UARTRX_CTRL2_RST;
      baud_q  <= `UARTRX_BAUD_RST;
    end else if (i_ce && i_bus.wr) begin
      if (i_bus.addr == `UARTRX_OFF_CTRL1) begin
        ctrl1_q <= {i_bus.wdata[7:2], ctrl1_q[`UARTRX_C1_RXB8], i_bus.wdata[0]};
      end else if (i_bus.addr == `UARTRX_OFF_CTRL2) begin
        ctrl2_q <= i_bus.wdata;
      end else if (i_bus.addr == `UARTRX_OFF_BAUD) begin
        baud_q <= i_bus.wdata;
      end
    end else if (i_ce && pop) begin
      // Ninth bit of the word being read lands in control one
      ctrl1_q[`UARTRX_C1_RXB8] <= head.data[8];
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      if (!i_bus.rd) begin
        rdata_q <= 8'h00;
      end else if (i_bus.addr == `UARTRX_OFF_STATUS) begin
        rdata_q <= status;
      end else if (i_bus.addr == `UARTRX_OFF_DATA) begin
        rdata_q <= head.data[7:0];
      end else if (i_bus.addr == `UARTRX_OFF_CTRL1) begin
        rdata_q <= ctrl1_q;
      end else if (i_bus.addr == `UARTRX_OFF_CTRL2) begin
        rdata_q <= ctrl2_q;
      end else if (i_bus.addr == `UARTRX_OFF_BAUD) begin
        rdata_q <= baud_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Receive events under the shared enable
  // Wake on a falling RX edge while the module clock is stopped
  always_comb begin
    irq_evt = 1'b0;
    if (ctrl2_q[`UARTRX_C2_RIE]) begin
      if (push && (!ctrl2_q[`UARTRX_C2_ADDR] || (nine ? word_in[8] : word_in[7]))) begin
        irq_evt = 1'b1;
      end
      if (stop_done && full) begin
        irq_evt = 1'b1;
      end
      if (i_clk_stopped && ctrl2_q[`UARTRX_C2_WAKE] && rx_prev_q && !i_rx) begin
        irq_evt = 1'b1;
      end
    end
    if (ctrl2_q[`UARTRX_C2_TEIE] && i_tx_empty) begin
      irq_evt = 1'b1;
    end
    if (ctrl2_q[`UARTRX_C2_TIIE] && i_tx_idle) begin
      irq_evt = 1'b1;
    end
  end

  // One-cycle low pulse per event; level transmit sources pulse continually
  // which the interrupt controller edge-captures
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_n_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (i_ce) begin
      rx_prev_q <= i_rx;
      irq_n_q   <= ~(irq_evt && irq_n_q);
    end
  end

  assign o_irq_n = irq_n_q;
  assign o_rdata = rdata_q;
endmodule : uartrx_core
`default_nettype wire

// >>> verilog/uartrx_pkg.sv
// Types shared by the UART receiver files
package uartrx_pkg;
  typedef enum logic [1:0] {
    UARTRX_IDLE  = 2'b00,
    UARTRX_START = 2'b01,
    UARTRX_DATA  = 2'b10,
    UARTRX_STOP  = 2'b11
  } uartrx_state_e;
  typedef struct packed {
    logic [8:0] data;
    logic       frame_err_flag;
    logic       parity_err_flag;
    logic       noise;
  } uartrx_word_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } uartrx_bus_s;
endpackage : uartrx_pkg

// >>> verilog/uartrx_vote.sv
// Three-sample majority voter with noise detection
`timescale 1ns/1ps
`default_nettype none
module uartrx_vote (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Sample control
  input  wire logic       i_clr,
  input  wire logic       i_take,
  input  wire logic       i_pin,
  // Decision
  output logic            o_level,
  output logic            o_noisy
);
  logic [2:0] samp_q;

  // Collect samples, shifting in on each take strobe
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      samp_q <= 3'h7;
    end else if (i_ce) begin
      if (i_clr) begin
        samp_q <= 3'h7;
      end else if (i_take) begin
        samp_q <= {samp_q[1:0], i_pin};
      end
    end
  end

  // Majority and disagreement; read by the caller only after three takes
  assign o_level = (samp_q[0] & samp_q[1]) | (samp_q[0] & samp_q[2]) | (samp_q[1] & samp_q[2]);
  assign o_noisy = ~((&samp_q) | ~(|samp_q));
endmodule : uartrx_vote
`default_nettype wire
